// ---- hdl/wdt_pkg.sv ----
// Purpose: shared constants and types of the windowed watchdog
// Assumes: 8-bit register port, one peripheral clock
// Notes: offsets are register indices on the plain register port

package wdt_pkg;

	localparam int unsigned ADDR_W = 3;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned CNT_W = 16;
	localparam int unsigned DIV_W = 7;
	localparam int unsigned PRE_W = 8;
	localparam int unsigned EV_W = 3;

	// register offsets
	localparam logic [ADDR_W-1:0] OFS_CTRL = 3'h0;
	localparam logic [ADDR_W-1:0] OFS_RELOAD = 3'h1;
	localparam logic [ADDR_W-1:0] OFS_WINB = 3'h2;
	localparam logic [ADDR_W-1:0] OFS_SERVICE = 3'h3;
	localparam logic [ADDR_W-1:0] OFS_CNT_LO = 3'h4;
	localparam logic [ADDR_W-1:0] OFS_CNT_HI = 3'h5;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 3'h6;
	localparam logic [ADDR_W-1:0] OFS_MASK = 3'h7;

	// control register fields
	localparam int unsigned CTRL_EN_BIT = 0;
	localparam int unsigned CTRL_PRESEL_BIT = 1;
	localparam int unsigned CTRL_WINEN_BIT = 2;
	localparam int unsigned CTRL_DBGRUN_BIT = 3;

	// status register fields: sticky events low, live state high
	localparam int unsigned EV_OVF_BIT = 0;
	localparam int unsigned EV_INV_BIT = 1;
	localparam int unsigned EV_PRE_BIT = 2;
	localparam int unsigned STAT_PREWARN_BIT = 4;
	localparam int unsigned STAT_FIRED_BIT = 5;

	// values after reset, and the counter top value
	localparam logic [DATA_W-1:0] RELOAD_RST = 8'h00;
	localparam logic [DATA_W-1:0] WINB_RST = 8'h00;
	localparam logic [EV_W-1:0] MASK_RST = 3'h0;
	localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
	localparam logic [CNT_W-1:0] CNT_TOP = 16'hffff;

	// prescaler: last divider value for divide-by-2 and divide-by-128
	localparam logic [DIV_W-1:0] DIV_FAST_LAST = 7'h01;
	localparam logic [DIV_W-1:0] DIV_SLOW_LAST = 7'h7f;

	// prewarning length in counter ticks
	localparam logic [PRE_W-1:0] PREWARN_COUNTS_RST = 8'h30;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_RUN = 4'h2,
		ST_PREWARN = 4'h4,
		ST_FIRED = 4'h8
	} wdt_fsm_t;

	typedef struct packed {
		wdt_fsm_t fsm;
		logic en;
		logic presel;
		logic win_en;
		logic dbg_run;
		logic [DATA_W-1:0] reload;
		logic [DATA_W-1:0] winb;
		logic [CNT_W-1:0] cnt;
		logic [DIV_W-1:0] div;
		logic [PRE_W-1:0] pre_cnt;
		logic [EV_W-1:0] status;
		logic [EV_W-1:0] mask;
		logic dbg_s1;
		logic dbg_s2;
		logic nmi;
		logic rst_out;
		logic irq;
		logic [DATA_W-1:0] rdata;
	} wdt_state_t;

endpackage

// ---- hdl/windowed_watchdog_timer.sv ----
// Purpose: windowed 16-bit watchdog with prewarning and system reset
// Assumes: i_clk is the peripheral clock, i_rstn the system reset
// Notes: all state lives in one packed struct, registered once

`timescale 1ns/1ps

// Function
// RULE1: 16-bit counter at clock/2 or clock/128
// RULE2: two byte stages, low byte cleared on service
// RULE3: valid service loads reload byte into high
// RULE4: unserviced overflow raises nmi, enters prewarning
// RULE5: prewarning lasts 30h ticks, then reset
// RULE6: refresh inside window: prewarning, no nmi
// RULE7: window spans zero up to boundary*256
// RULE8: counting stops in debug by default
// RULE9: period equals prescale times (65536-reload*256)
// RULE10: boundary above reload shortens effective period
// RULE11: software services before every overflow
// RULE12: software keeps boundary not below reload
// RULE13: window check only when window enabled
module windowed_watchdog_timer #(
	parameter int unsigned CNT_WIDTH = 16,
	parameter logic [7:0] PREWARN_COUNTS = wdt_pkg::PREWARN_COUNTS_RST
) (
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic [wdt_pkg::ADDR_W-1:0] i_addr,
	input wire logic [wdt_pkg::DATA_W-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic i_debug_mode,
	output logic [wdt_pkg::DATA_W-1:0] o_rdata,
	output logic o_irq,
	output logic o_watchdog_nmi_request,
	output logic o_watchdog_reset_out
);
	import wdt_pkg::*;

	// the byte-stage split and read map assume exactly two 8-bit stages
	if (CNT_WIDTH != CNT_W) begin : g_bad_width
		$error("counter width must be 16");
	end
	if (PREWARN_COUNTS == 8'h00) begin : g_bad_prewarn
		$error("prewarning length must be nonzero");
	end

	wdt_state_t s;
	wdt_state_t n;

	logic svc_req;
	logic running;
	logic tick;
	logic ev_ovf;
	logic ev_inv;
	logic ev_pre;
	logic [EV_W-1:0] ev_vec;
	logic [EV_W-1:0] clr_vec;

	// last divider value before a counter tick, per prescale select
	function automatic logic [DIV_W-1:0] div_last(input logic presel);
		return presel ? DIV_SLOW_LAST : DIV_FAST_LAST;
	endfunction

	// forbidden window: counts below boundary byte with zero low byte
	function automatic logic in_window(
		input logic [CNT_W-1:0] cnt,
		input logic [DATA_W-1:0] winb
	);
		return cnt < {winb, 8'h00};
	endfunction

	// register read map; unmapped bits read as zero
	function automatic logic [DATA_W-1:0] read_value(
		input wdt_state_t st,
		input logic [ADDR_W-1:0] addr
	);
		logic [DATA_W-1:0] v;
		v = 8'h00;
		unique case (addr)
			OFS_CTRL: begin
				v[CTRL_EN_BIT] = st.en;
				v[CTRL_PRESEL_BIT] = st.presel;
				v[CTRL_WINEN_BIT] = st.win_en;
				v[CTRL_DBGRUN_BIT] = st.dbg_run;
			end
			OFS_RELOAD: begin
				v = st.reload;
			end
			OFS_WINB: begin
				v = st.winb;
			end
			OFS_SERVICE: begin
				v = 8'h00;
			end
			OFS_CNT_LO: begin
				v = st.cnt[7:0];
			end
			OFS_CNT_HI: begin
				v = st.cnt[15:8];
			end
			OFS_STATUS: begin
				v[EV_W-1:0] = st.status;
				v[STAT_PREWARN_BIT] = (st.fsm == ST_PREWARN);
				v[STAT_FIRED_BIT] = (st.fsm == ST_FIRED);
			end
			OFS_MASK: begin
				v[EV_W-1:0] = st.mask;
			end
		endcase
		return v;
	endfunction

	always_comb begin
		n = s;
		svc_req = i_wr && (i_addr == OFS_SERVICE);
		ev_ovf = 1'b0;
		ev_inv = 1'b0;
		ev_pre = 1'b0;

		// debug level comes from another domain: two flops first
		n.dbg_s1 = i_debug_mode;
		n.dbg_s2 = s.dbg_s1;

		// suspended in debug unless software asked it to keep running
		running = (s.fsm != ST_IDLE) && (s.fsm != ST_FIRED)
			&& !(s.dbg_s2 && !s.dbg_run); // RULE8

		// one-cycle enable from the prescaler
		tick = running && (s.div >= div_last(s.presel)); // RULE1
		if (!running) begin
			n.div = s.div;
		end else if (tick) begin
			n.div = 7'h00;
		end else begin
			n.div = s.div + 7'h01;
		end

		unique case (s.fsm)
			ST_IDLE: begin
				n.div = 7'h00;
				if (s.en) begin
					n.fsm = ST_RUN;
				end
			end
			ST_RUN: begin
				if (!s.en) begin
					n.fsm = ST_IDLE;
				end else if (svc_req) begin
					// window check only when it is switched on
					if (s.win_en && in_window(s.cnt, s.winb)) begin // RULE13
						// early refresh: prewarning without nmi
						ev_inv = 1'b1; // RULE6 RULE7 RULE10
						ev_pre = 1'b1;
						n.pre_cnt = 8'h00;
						n.fsm = ST_PREWARN;
					end else begin
						// high byte from reload, low stage cleared
						n.cnt = {s.reload, 8'h00}; // RULE2 RULE3 RULE9
					end
				end else if (tick) begin
					if (s.cnt == CNT_TOP) begin
						// unserviced overflow
						ev_ovf = 1'b1; // RULE4
						ev_pre = 1'b1;
						n.cnt = CNT_RST;
						n.pre_cnt = 8'h00;
						n.fsm = ST_PREWARN;
					end else begin
						n.cnt = s.cnt + 16'h0001; // RULE1
					end
				end
			end
			ST_PREWARN: begin
				// services and disable are ignored once prewarning runs
				if (tick) begin
					n.cnt = s.cnt + 16'h0001;
					n.pre_cnt = s.pre_cnt + 8'h01;
					if (s.pre_cnt == PREWARN_COUNTS - 8'h01) begin
						n.fsm = ST_FIRED; // RULE5
					end
				end
			end
			ST_FIRED: begin
				// held until the system reset comes back
				n.fsm = ST_FIRED;
			end
			default: begin
				// an upset can leave an illegal one-hot code
				n.fsm = ST_IDLE;
			end
		endcase

		// register writes
		clr_vec = 3'h0;
		if (i_wr) begin
			unique case (i_addr)
				OFS_CTRL: begin
					n.en = i_wdata[CTRL_EN_BIT];
					n.presel = i_wdata[CTRL_PRESEL_BIT];
					n.win_en = i_wdata[CTRL_WINEN_BIT];
					n.dbg_run = i_wdata[CTRL_DBGRUN_BIT];
				end
				OFS_RELOAD: begin
					n.reload = i_wdata;
				end
				OFS_WINB: begin
					n.winb = i_wdata;
				end
				OFS_STATUS: begin
					clr_vec = i_wdata[EV_W-1:0];
				end
				OFS_MASK: begin
					n.mask = i_wdata[EV_W-1:0];
				end
				default: begin
					// service strobe and read-only counter bytes
					n.mask = s.mask;
				end
			endcase
		end

		// sticky events: a set in the clearing cycle wins
		ev_vec = 3'h0;
		ev_vec[EV_OVF_BIT] = ev_ovf;
		ev_vec[EV_INV_BIT] = ev_inv;
		ev_vec[EV_PRE_BIT] = ev_pre;
		n.status = (s.status & ~clr_vec) | ev_vec;

		// nmi is not maskable; it follows the overflow flag
		n.nmi = n.status[EV_OVF_BIT]; // RULE4
		n.rst_out = (n.fsm == ST_FIRED); // RULE5
		n.irq = |(n.status & n.mask);

		// read data valid only in the cycle after the strobe
		n.rdata = i_rd ? read_value(s, i_addr) : 8'h00;
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			s.fsm <= ST_IDLE;
			s.en <= 1'b0;
			s.presel <= 1'b0;
			s.win_en <= 1'b0;
			s.dbg_run <= 1'b0;
			s.reload <= RELOAD_RST;
			s.winb <= WINB_RST;
			s.cnt <= CNT_RST;
			s.div <= 7'h00;
			s.pre_cnt <= 8'h00;
			s.status <= 3'h0;
			s.mask <= MASK_RST;
			s.dbg_s1 <= 1'b0;
			s.dbg_s2 <= 1'b0;
			s.nmi <= 1'b0;
			s.rst_out <= 1'b0;
			s.irq <= 1'b0;
			s.rdata <= 8'h00;
		end else begin
			s <= n;
		end
	end

	assign o_rdata = s.rdata;
	assign o_irq = s.irq;
	assign o_watchdog_nmi_request = s.nmi;
	assign o_watchdog_reset_out = s.rst_out;

endmodule

// ---- testbench/testbench.sv ----
// Purpose: self-checking bench of the windowed watchdog
// Assumes: prewarning shortened to 4 ticks
// Notes: run-in-debug is set only in the debug scenario; tasks from t_window on reset first
`timescale 1ns/1ps
module testbench;
	import wdt_pkg::*;
	logic clk = 0, rstn = 0, wr = 0, rd = 0, dbg = 0;
	logic [2:0] addr = '0;
	logic [7:0] wdata = '0, rdata, d;
	logic irq, nmi, wrst;
	int errors = 0, tests_run = 0, n;
	always #2 clk = ~clk;
	windowed_watchdog_timer #(.PREWARN_COUNTS(8'h04)) u_dut (
		.i_clk(clk), .i_rstn(rstn), .i_addr(addr), .i_wdata(wdata),
		.i_wr(wr), .i_rd(rd), .i_debug_mode(dbg), .o_rdata(rdata),
		.o_irq(irq), .o_watchdog_nmi_request(nmi),
		.o_watchdog_reset_out(wrst));
	task automatic chk(string s, logic [7:0] seen, logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch %s exp %h seen %h", s, exp, seen);
		end
	endtask
	task automatic wr_reg(logic [2:0] a, logic [7:0] v);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(logic [2:0] a);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		d = rdata;
	endtask
	// bounded wait; on exit n holds the cycles spent
	task automatic wait_for(input bit nmi_not_rst);
		n = 0;
		while ((nmi_not_rst ? nmi : wrst) !== 1'b1 && n < 3000) begin
			@(negedge clk);
			n++;
		end
	endtask
	task automatic do_reset();
		@(posedge clk);
		rstn <= 1'b0;
		dbg <= 1'b0;
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
	endtask
	task automatic complete_run();
		$display("comparisons %0d errors %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic t_defaults();
		logic [2:0] al [5] = '{OFS_CTRL, OFS_RELOAD, OFS_WINB, OFS_STATUS,
			OFS_MASK};
		foreach (al[i]) begin
			rd_reg(al[i]);
			chk("default", d, 8'h00);
		end
		$display("done defaults");
	endtask
	task automatic t_overflow();
		wr_reg(OFS_RELOAD, 8'hff);
		wr_reg(OFS_MASK, 8'h01);
		wr_reg(OFS_CTRL, 8'h01);
		wr_reg(OFS_SERVICE, 8'h5a);
		rd_reg(OFS_CNT_HI);
		chk("cnt_hi", d, 8'hff);
		rd_reg(OFS_CNT_LO);
		chk("cnt_lo", 8'(d < 8'h04), 8'h01);
		wr_reg(OFS_SERVICE, 8'h00);
		wait_for(1'b1);
		// 256 ticks of two clocks, plus divider phase and flop delay
		chk("period", 8'(n >= 510 && n <= 515), 8'h01);
		chk("irq", {7'h0, irq}, 8'h01);
		wait_for(1'b0);
		chk("prewarn", 8'(n >= 6 && n <= 10), 8'h01);
		rd_reg(OFS_STATUS);
		chk("status", d & 8'h07, 8'h05);
		chk("fired", d & 8'h30, 8'h20);
		wr_reg(OFS_STATUS, 8'h01);
		repeat (3) @(negedge clk);
		chk("nmi_clr", {7'h0, nmi}, 8'h00);
		chk("sticky", {7'h0, wrst}, 8'h01);
		$display("done overflow");
	endtask
	task automatic t_window(logic [7:0] ctrl, logic [7:0] st);
		do_reset();
		wr_reg(OFS_WINB, 8'h80);
		wr_reg(OFS_RELOAD, 8'h12);
		wr_reg(OFS_CTRL, ctrl);
		wr_reg(OFS_SERVICE, 8'h00);
		rd_reg(OFS_STATUS);
		chk("win_status", d & 8'h07, st);
		chk("win_live", {7'h0, d[4]}, {7'h0, st != 8'h00});
		chk("win_nmi", {7'h0, nmi}, 8'h00);
		rd_reg(OFS_CNT_HI);
		chk("win_hi", d, st == 8'h00 ? 8'h12 : 8'h00);
		wait_for(1'b0);
		chk("win_rst", {7'h0, wrst}, st == 8'h00 ? 8'h00 : 8'h01);
		$display("done window %h", ctrl);
	endtask
	task automatic t_debug();
		logic [7:0] c0;
		do_reset();
		dbg <= 1'b1;
		wr_reg(OFS_CTRL, 8'h01);
		repeat (50) @(posedge clk);
		rd_reg(OFS_CNT_LO);
		chk("dbg_hold", d, 8'h00);
		@(posedge clk);
		dbg <= 1'b0;
		repeat (20) @(posedge clk);
		rd_reg(OFS_CNT_LO);
		chk("dbg_run", 8'(d != 8'h00), 8'h01);
		// run-in-debug set: debug must no longer freeze the count
		wr_reg(OFS_CTRL, 8'h09);
		@(posedge clk);
		dbg <= 1'b1;
		repeat (4) @(posedge clk);
		rd_reg(OFS_CNT_LO);
		c0 = d;
		repeat (20) @(posedge clk);
		rd_reg(OFS_CNT_LO);
		chk("dbg_keep", 8'(d != c0), 8'h01);
		$display("done debug");
	endtask
	task automatic t_dbg_prewarn();
		do_reset();
		wr_reg(OFS_WINB, 8'h80);
		wr_reg(OFS_CTRL, 8'h05);
		wr_reg(OFS_SERVICE, 8'h00);
		@(posedge clk);
		dbg <= 1'b1;
		repeat (40) @(negedge clk);
		chk("dbg_prewarn", {7'h0, wrst}, 8'h00);
		@(posedge clk);
		dbg <= 1'b0;
		wait_for(1'b0);
		chk("dbg_fire", {7'h0, wrst}, 8'h01);
		$display("done debug prewarning");
	endtask
	task automatic t_slow();
		do_reset();
		wr_reg(OFS_RELOAD, 8'hff);
		wr_reg(OFS_CTRL, 8'h03);
		wr_reg(OFS_SERVICE, 8'h00);
		// 300 clocks at one tick per 128 clocks: exactly two ticks
		repeat (300) @(posedge clk);
		rd_reg(OFS_CNT_LO);
		chk("slow_lo", d, 8'h02);
		$display("done slow");
	endtask
	task automatic t_win_ok();
		do_reset();
		wr_reg(OFS_RELOAD, 8'hfe);
		wr_reg(OFS_WINB, 8'hff);
		wr_reg(OFS_CTRL, 8'h01);
		wr_reg(OFS_SERVICE, 8'h00);
		wr_reg(OFS_CTRL, 8'h05);
		// past the boundary (256 ticks) but well before overflow
		repeat (520) @(posedge clk);
		wr_reg(OFS_SERVICE, 8'h00);
		rd_reg(OFS_STATUS);
		chk("late_status", d, 8'h00);
		rd_reg(OFS_CNT_HI);
		chk("late_hi", d, 8'hfe);
		wait_for(1'b1);
		// 512 ticks of two clocks, less the read cycles already spent
		chk("late_period", 8'(n >= 1015 && n <= 1025), 8'h01);
		$display("done late service");
	endtask
	initial begin
		#40000;
		errors++;
		complete_run();
	end
	initial begin
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		t_defaults();
		t_overflow();
		t_window(8'h05, 8'h06);
		t_window(8'h01, 8'h00);
		t_debug();
		t_dbg_prewarn();
		t_slow();
		t_win_ok();
		complete_run();
	end
endmodule

// ---- testbench/wdt_checker.sv ----
// Purpose: port-level checks of the windowed watchdog
// Assumes: prewarning of at least 4 ticks
// Notes: counter state is hidden, so checks tie outputs to strobes
`timescale 1ns/1ps
module wdt_checker import wdt_pkg::*; #(
	parameter logic [7:0] PREWARN_COUNTS = 8'h30
) (
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [DATA_W-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic i_debug_mode,
	input wire logic [DATA_W-1:0] o_rdata,
	input wire logic o_irq,
	input wire logic o_watchdog_nmi_request,
	input wire logic o_watchdog_reset_out
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rstn);
	// shadow of the run-in-debug bit: debug only freezes the count without it
	logic keep_dbg_ff;
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			keep_dbg_ff <= 1'b0;
		end else if (i_wr && i_addr == OFS_CTRL) begin
			keep_dbg_ff <= i_wdata[CTRL_DBGRUN_BIT];
		end
	end
	rdata_idle_a: assert property (
		!$past(i_rd) |-> o_rdata == 8'h00) else $error("rdata not idle");
	service_read_a: assert property (
		$past(i_rd) && $past(i_addr) == OFS_SERVICE |-> o_rdata == 8'h00)
		else $error("service read not zero");
	reset_zero_a: assert property (
		$rose(i_rstn) |-> !o_irq && !o_watchdog_nmi_request
		&& !o_watchdog_reset_out) else $error("outputs after reset");
	nmi_first_a: assert property (
		$rose(o_watchdog_nmi_request) |-> !o_watchdog_reset_out)
		else $error("nmi after system reset");
	prewarn_len_a: assert property (
		$rose(o_watchdog_nmi_request) |=> (!o_watchdog_reset_out) [*6])
		else $error("prewarning too short");
	rst_sticky_a: assert property (
		o_watchdog_reset_out |=> o_watchdog_reset_out)
		else $error("system reset dropped");
	nmi_clear_a: assert property (
		$fell(o_watchdog_nmi_request) |-> ($past(i_wr)
		&& $past(i_addr) == OFS_STATUS) || ($past(i_wr, 2)
		&& $past(i_addr, 2) == OFS_STATUS)) else $error("nmi fell alone");
	debug_hold_a: assert property (
		$rose(o_watchdog_reset_out) && !$past(keep_dbg_ff) |->
		!($past(i_debug_mode, 2) && $past(i_debug_mode, 3)))
		else $error("counted in debug");
endmodule

bind windowed_watchdog_timer wdt_checker #(
	.PREWARN_COUNTS(PREWARN_COUNTS)
) u_chk (.i_clk(i_clk), .i_rstn(i_rstn), .i_addr(i_addr),
	.i_wdata(i_wdata), .i_wr(i_wr),
	.i_rd(i_rd), .i_debug_mode(i_debug_mode), .o_rdata(o_rdata),
	.o_irq(o_irq), .o_watchdog_nmi_request(o_watchdog_nmi_request),
	.o_watchdog_reset_out(o_watchdog_reset_out));
